/* File: rtl/udtc_pkg.sv */
`default_nettype none
// Shared constants for the up/down threshold counter.
package udtc_pkg;
	// Width of the count and of both thresholds.
	localparam int CNT_W = 20;
	// Largest threshold value that the block accepts.
	localparam logic [CNT_W-1:0] THR_MAX = 20'hf423f;
	// Largest count before upward counting saturates.
	localparam logic [CNT_W-1:0] CNT_FULL = 20'hfffff;
	// Smallest count before downward counting saturates.
	localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
	// Byte addresses of the registers.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_INIT = 8'h04;
	localparam logic [7:0] ADDR_SET_THR = 8'h08;
	localparam logic [7:0] ADDR_CLR_THR = 8'h0c;
	localparam logic [7:0] ADDR_COUNT = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	// Control register bit positions.
	localparam int CTRL_RETAIN_BIT = 0;
	localparam int CTRL_SET_EXT_BIT = 1;
	localparam int CTRL_CLR_EXT_BIT = 2;
	localparam int CTRL_W = 3;
	// Status register bit positions.
	localparam int STAT_OUT_BIT = 0;
	localparam int STAT_WINDOW_BIT = 1;
	localparam int STAT_RESET_BIT = 2;
	// Values after reset.
	localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
	localparam logic [CNT_W-1:0] INIT_RST = 20'h00000;
	localparam logic [CNT_W-1:0] SET_THR_RST = 20'h00000;
	localparam logic [CNT_W-1:0] CLR_THR_RST = 20'h00000;
	// AXI response codes.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : udtc_pkg
`default_nettype wire

/* File: rtl/udtc_edge.sv */
`default_nettype none
// Rising edge detector on a level sampled every clock.
module udtc_edge
	import udtc_pkg::*;
(
	input wire logic aclk, // System clock.
	input wire logic aresetn, // Synchronous reset, active low.
	input wire logic level_in, // Sampled level.
	output logic rise // High for one cycle on a 0 to 1 change.
);
	logic prev_r; // Level seen at the previous sample.
	logic prev_nxt; // Next stored level.

	// The stored level simply follows the input.
	always_comb
	begin
		prev_nxt = level_in;
	end

	// Register the previous level.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			prev_r <= 1'b0;
		else
			prev_r <= prev_nxt;
	end

	// An edge is a low stored level against a high current one.
	assign rise = level_in && !prev_r; // [R14]
endmodule // udtc_edge
`default_nettype wire

/* File: rtl/udtc_clamp.sv */
`default_nettype none
// Clamps a signed 32-bit value into the legal threshold range.
module udtc_clamp
	import udtc_pkg::*;
(
	input wire logic [31:0] value_in, // Raw signed value.
	output logic [CNT_W-1:0] value_out // Value limited to 0 .. THR_MAX.
);
	// Negative values go to zero and large values to the maximum.
	always_comb
	begin
		if (value_in[31])
			value_out = CNT_ZERO; // [R13]
		else if (value_in > {12'h000, THR_MAX})
			value_out = THR_MAX; // [R13]
		else
			value_out = value_in[CNT_W-1:0];
	end
endmodule // udtc_clamp
`default_nettype wire

/* File: rtl/udtc_counter.sv */
// Operation
// [R1] Reset input loads the initial count value.
// [R2] Only rising pulse edges change the count.
// [R3] Each rising edge counts one, direction selects.
// [R4] While reset input high, output low, pulses ignored.
// [R5] Thresholds accept values zero to 999999.
// [R6] Software sets the initial count value.
// [R7] Without retention, power loss clears count and output.
// [R8] Retention setting keeps count over power loss.
// [R9] Hysteresis: set at set threshold, clear below clear.
// [R10] Window: output high inside set to clear.
// [R11] Threshold compare runs once per scan cycle.
// [R12] Thresholds may come from another block's value.
// [R13] Out of range external thresholds are clamped.
// [R14] Edge found from current against previous sample.
// [R15] Hysteresis output holds between the two thresholds.
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`default_nettype none
module udtc_counter
	import udtc_pkg::*;
(
	input wire logic aclk, // System clock, 40 MHz.
	input wire logic aresetn, // Synchronous reset, active low.
	input wire logic [7:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write byte enables.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [7:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	input wire logic count_pulse, // Pulse input whose rising edges are counted.
	input wire logic count_down, // Direction: 0 counts up, 1 counts down.
	input wire logic count_reset, // Level reset of the count.
	input wire logic scan_tick, // One-cycle pulse at each program scan.
	input wire logic power_lost, // One-cycle pulse when power returns after a loss.
	input wire logic [31:0] ext_set_value, // Live value of another block for the set threshold.
	input wire logic [31:0] ext_clr_value, // Live value of another block for the clear threshold.
	output logic switch_out, // Switched output.
	output logic [CNT_W-1:0] count_value // Current count.
);
	// Write channel state.
	logic aw_got_r, aw_got_nxt; // Write address held.
	logic w_got_r, w_got_nxt; // Write data held.
	logic [7:0] waddr_r, waddr_nxt; // Held write address.
	logic [31:0] wdata_r, wdata_nxt; // Held write data.
	logic [3:0] wstrb_r, wstrb_nxt; // Held byte enables.
	logic bvalid_r, bvalid_nxt; // Write response pending.
	logic [1:0] bresp_r, bresp_nxt; // Write response code.
	logic wr_fire; // Both halves held, write takes effect now.
	// Read channel state.
	logic rvalid_r, rvalid_nxt; // Read data pending.
	logic [31:0] rdata_r, rdata_nxt; // Read data.
	logic [1:0] rresp_r, rresp_nxt; // Read response code.
	// Software registers.
	logic [CTRL_W-1:0] ctrl_r, ctrl_nxt; // Retention and threshold source.
	logic [CNT_W-1:0] init_r, init_nxt; // Initial count value.
	logic [CNT_W-1:0] set_thr_r, set_thr_nxt; // Software set threshold.
	logic [CNT_W-1:0] clr_thr_r, clr_thr_nxt; // Software clear threshold.
	logic [31:0] wr_cur; // Present value of the addressed register.
	logic [31:0] wr_merged; // Held data merged under the byte enables.
	logic [CNT_W-1:0] wr_clamped; // Merged data limited to the legal range.
	// Counter core.
	logic [CNT_W-1:0] count_r, count_nxt; // Internal count.
	logic out_r, out_nxt; // Switched output.
	logic pulse_rise; // Rising edge on the pulse input.
	logic [CNT_W-1:0] ext_set_clamped; // External set threshold, clamped.
	logic [CNT_W-1:0] ext_clr_clamped; // External clear threshold, clamped.
	logic [CNT_W-1:0] set_eff; // Set threshold in use.
	logic [CNT_W-1:0] clr_eff; // Clear threshold in use.
	logic window_mode; // Set threshold below clear threshold.

	// Edge detector on the pulse input.
	udtc_edge u_edge (
		.aclk(aclk),
		.aresetn(aresetn),
		.level_in(count_pulse),
		.rise(pulse_rise)
	);
	// Limit software writes to the legal threshold range.
	udtc_clamp u_clamp_wr (
		.value_in(wr_merged),
		.value_out(wr_clamped)
	);
	// Limit the external set threshold.
	udtc_clamp u_clamp_set (
		.value_in(ext_set_value),
		.value_out(ext_set_clamped)
	);
	// Limit the external clear threshold.
	udtc_clamp u_clamp_clr (
		.value_in(ext_clr_value),
		.value_out(ext_clr_clamped)
	);
	// Pick each threshold from software or from the other block.
	assign set_eff = ctrl_r[CTRL_SET_EXT_BIT] ? ext_set_clamped : set_thr_r; // [R12]
	assign clr_eff = ctrl_r[CTRL_CLR_EXT_BIT] ? ext_clr_clamped : clr_thr_r; // [R12]
	assign window_mode = set_eff < clr_eff;
	// Address and data are taken separately, in either order.
	assign s_axi_awready = !aw_got_r && !bvalid_r;
	assign s_axi_wready = !w_got_r && !bvalid_r;
	assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	// Write channel: hold both halves, then answer once.
	always_comb
	begin
		aw_got_nxt = aw_got_r;
		w_got_nxt = w_got_r;
		waddr_nxt = waddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		// Catch the address.
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_got_nxt = 1'b1;
			waddr_nxt = s_axi_awaddr;
		end
		// Catch the data.
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_got_nxt = 1'b1;
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		// Issue the response once the write is done.
		if (wr_fire)
		begin
			aw_got_nxt = 1'b0;
			w_got_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			case ({waddr_r[7:2], 2'b00})
				ADDR_CTRL, ADDR_INIT, ADDR_SET_THR, ADDR_CLR_THR: bresp_nxt = RESP_OKAY;
				default: bresp_nxt = RESP_SLVERR; // Read-only or unmapped.
			endcase
		end
		else if (bvalid_r && s_axi_bready)
			bvalid_nxt = 1'b0;
	end

	// Register the write channel.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			waddr_r <= 8'h00;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end
		else
		begin
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			waddr_r <= waddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
		end
	end

	// Software registers: merge byte lanes, clamp values, store.
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		init_nxt = init_r;
		set_thr_nxt = set_thr_r;
		clr_thr_nxt = clr_thr_r;
		// Present contents of the addressed register.
		case ({waddr_r[7:2], 2'b00})
			ADDR_CTRL: wr_cur = {29'h00000000, ctrl_r};
			ADDR_INIT: wr_cur = {12'h000, init_r};
			ADDR_SET_THR: wr_cur = {12'h000, set_thr_r};
			ADDR_CLR_THR: wr_cur = {12'h000, clr_thr_r};
			default: wr_cur = 32'h00000000;
		endcase
		// Replace only the enabled byte lanes.
		for (int b = 0; b < 4; b++)
			wr_merged[b*8 +: 8] = wstrb_r[b] ? wdata_r[b*8 +: 8] : wr_cur[b*8 +: 8];
		// Store into the addressed register.
		if (wr_fire)
		begin
			case ({waddr_r[7:2], 2'b00})
				ADDR_CTRL: ctrl_nxt = wr_merged[CTRL_W-1:0];
				ADDR_INIT: init_nxt = wr_clamped; // [R6]
				ADDR_SET_THR: set_thr_nxt = wr_clamped; // [R5]
				ADDR_CLR_THR: clr_thr_nxt = wr_clamped; // [R5]
				default: ctrl_nxt = ctrl_r; // Nothing writable here.
			endcase
		end
	end

	// Register the software registers.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_r <= CTRL_RST;
			init_r <= INIT_RST;
			set_thr_r <= SET_THR_RST;
			clr_thr_r <= CLR_THR_RST;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			init_r <= init_nxt;
			set_thr_r <= set_thr_nxt;
			clr_thr_r <= clr_thr_nxt;
		end
	end
	// One read at a time; a new address is taken only when idle.
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// Read channel: decode and answer one cycle after the address.
	always_comb
	begin
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'b00})
				ADDR_CTRL: rdata_nxt = {29'h00000000, ctrl_r};
				ADDR_INIT: rdata_nxt = {12'h000, init_r};
				ADDR_SET_THR: rdata_nxt = {12'h000, set_thr_r};
				ADDR_CLR_THR: rdata_nxt = {12'h000, clr_thr_r};
				ADDR_COUNT: rdata_nxt = {12'h000, count_r};
				ADDR_STATUS: rdata_nxt = {29'h00000000, count_reset, window_mode, out_r};
				default:
				begin
					// Unmapped addresses read zero with an error.
					rdata_nxt = 32'h00000000;
					rresp_nxt = RESP_SLVERR;
				end
			endcase
		end
		else if (rvalid_r && s_axi_rready)
			rvalid_nxt = 1'b0;
	end

	// Register the read channel.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= RESP_OKAY;
		end
		else
		begin
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// Counter core: power loss first, then the reset input, then counting.
	always_comb
	begin
		count_nxt = count_r;
		out_nxt = out_r;
		if (power_lost && !ctrl_r[CTRL_RETAIN_BIT])
		begin
			// Without retention the state is lost.
			count_nxt = CNT_ZERO; // [R7]
			out_nxt = 1'b0; // [R7]
		end
		else if (count_reset)
		begin
			// Hold the start value and a low output; edges are dropped.
			count_nxt = init_r; // [R1] [R4]
			out_nxt = 1'b0; // [R4]
		end
		else
		begin
			// With retention a power loss leaves the count alone.
			if (pulse_rise) // [R2] [R8]
			begin
				if (!count_down && count_r != CNT_FULL)
					count_nxt = count_r + 20'h00001; // [R3]
				else if (count_down && count_r != CNT_ZERO)
					count_nxt = count_r - 20'h00001; // [R3]
			end
			// The thresholds are compared once per scan.
			if (scan_tick) // [R11]
			begin
				if (window_mode)
					out_nxt = (count_r >= set_eff) && (count_r < clr_eff); // [R10]
				else if (count_r >= set_eff)
					out_nxt = 1'b1; // [R9]
				else if (count_r < clr_eff)
					out_nxt = 1'b0; // [R9]
				else
					out_nxt = out_r; // [R15]
			end
		end
	end

	// Register the counter core.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count_r <= CNT_ZERO;
			out_r <= 1'b0;
		end
		else
		begin
			count_r <= count_nxt;
			out_r <= out_nxt;
		end
	end
	// Data outputs come straight from the core flip-flops.
	assign switch_out = out_r;
	assign count_value = count_r;
endmodule // udtc_counter
`default_nettype wire

/* File: verif/udtc_counter_props.sv */
`default_nettype none
// Port-level checks of the counting core and of the bus answer timing.
module udtc_props
	import udtc_pkg::*;
(
	input wire logic aclk, // Clock.
	input wire logic aresetn, // Reset, active low.
	input wire logic s_axi_awvalid, // Write address valid.
	input wire logic s_axi_awready, // Write address ready.
	input wire logic s_axi_wvalid, // Write data valid.
	input wire logic s_axi_wready, // Write data ready.
	input wire logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_arvalid, // Read address valid.
	input wire logic s_axi_arready, // Read address ready.
	input wire logic s_axi_rvalid, // Read data valid.
	input wire logic count_pulse, // Counted pulse line.
	input wire logic count_down, // Direction.
	input wire logic count_reset, // Level reset of the count.
	input wire logic scan_tick, // Scan strobe.
	input wire logic power_lost, // Power return strobe.
	input wire logic switch_out, // Switched output.
	input wire logic [CNT_W-1:0] count_value // Current count.
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// A rising pulse edge that neither reset nor power loss overrides.
	sequence up_s;
		$rose(count_pulse) && !count_down && !count_reset && !power_lost;
	endsequence
	sequence dn_s;
		$rose(count_pulse) && count_down && !count_reset && !power_lost;
	endsequence
	// Both write halves are taken at the same edge.
	sequence wr_take_s;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	step_up_a: assert property (up_s ##0 (count_value != CNT_FULL) |=>
		count_value == $past(count_value) + 20'h1) else $error("count did not step up");
	step_down_a: assert property (dn_s ##0 (count_value != CNT_ZERO) |=>
		count_value == $past(count_value) - 20'h1) else $error("count did not step down");
	sat_low_a: assert property (dn_s ##0 (count_value == CNT_ZERO) |=>
		count_value == CNT_ZERO) else $error("count wrapped below zero");
	fall_ignore_a: assert property (!count_pulse && !count_reset && !power_lost |=>
		$stable(count_value)) else $error("count moved without a rising edge");
	reset_out_a: assert property (count_reset |=> !switch_out)
		else $error("output high while reset input held");
	reset_freeze_a: assert property ((count_reset && !power_lost) [*2] |=>
		$stable(count_value)) else $error("count moved while reset input held");
	scan_hold_a: assert property (!scan_tick && !count_reset && !power_lost |=>
		$stable(switch_out)) else $error("output changed between scans");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	wr_answer_a: assert property (wr_take_s |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer not two edges after take");
	ready_drop_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write ready while response pending");
endmodule // udtc_props
bind udtc_counter udtc_props i_udtc_props (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .count_pulse(count_pulse), .count_down(count_down),
	.count_reset(count_reset), .scan_tick(scan_tick), .power_lost(power_lost),
	.switch_out(switch_out), .count_value(count_value));
`default_nettype wire

/* File: verif/udtc_pulse_src.sv */
`default_nettype none
// Digital input feeding the counter: each pulse is high one cycle, then low one cycle.
module udtc_pulse_src
(
	input wire logic aclk, // Clock.
	output logic count_pulse, // Pulse line.
	output logic count_down // Direction line.
);
	timeunit 1ns;
	timeprecision 1ps;
	// Lines rest low from time zero.
	initial
	begin
		count_pulse = 1'b0;
		count_down = 1'b0;
	end
	// Direction settles before the rising edge so the step sees it.
	task automatic fire(input logic dir);
		count_down <= dir;
		@(posedge aclk);
		count_pulse <= 1'b1;
		@(posedge aclk);
		count_pulse <= 1'b0;
		@(posedge aclk);
	endtask
endmodule // udtc_pulse_src
`default_nettype wire

/* File: verif/udtc_counter_tb.sv */
`default_nettype none
// Self-checking bench for the threshold counter.
module udtc_counter_tb;
	import udtc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic awvalid = 1'b0;
	logic awready;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic wvalid = 1'b0;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b0;
	logic [7:0] araddr = 8'h00;
	logic arvalid = 1'b0;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b0;
	logic count_pulse;
	logic count_down;
	logic count_reset = 1'b0;
	logic scan_tick = 1'b0;
	logic power_lost = 1'b0;
	logic [31:0] ext_set = 32'h0;
	logic [31:0] ext_clr = 32'h0;
	logic switch_out;
	logic [CNT_W-1:0] count_value;
	int seed = 34270;
	int miscompares = 0;
	int checked = 0;
	logic [CNT_W-1:0] exp_cnt, s, k;
	logic exp_out;
	logic [31:0] rv;
	int r;
	udtc_counter i_udtc_counter (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.count_pulse(count_pulse), .count_down(count_down), .count_reset(count_reset),
		.scan_tick(scan_tick), .power_lost(power_lost), .ext_set_value(ext_set),
		.ext_clr_value(ext_clr), .switch_out(switch_out), .count_value(count_value));
	udtc_pulse_src i_udtc_pulse_src (.aclk(aclk), .count_pulse(count_pulse),
		.count_down(count_down));
	// Clock at 40 MHz.
	initial
	begin
		forever #12.5 aclk = ~aclk;
	end
	// Expected output after one scan, hysteresis or window by threshold order.
	function automatic logic next_out(input logic [CNT_W-1:0] c, st, cl, input logic prev);
		if (st >= cl)
		begin
			if (c >= st) return 1'b1;
			if (c < cl) return 1'b0;
			return prev;
		end
		return (c >= st) && (c < cl);
	endfunction
	// Expected count after one pulse, saturating at both ends.
	function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] c, input logic d);
		if (d) return (c == CNT_ZERO) ? c : c - 20'h1;
		return (c == CNT_FULL) ? c : c + 20'h1;
	endfunction
	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("checked %0d, miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// A wait that ran out ends the run as a failure.
	task automatic hang();
		miscompares++;
		conclude();
	endtask
	// Compares one value and reports a mismatch.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Bus write; each half drops when taken, bready stays up until bvalid.
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			n++;
		end
		while (bvalid !== 1'b1 && n < 50);
		if (n >= 50) hang();
		bready <= 1'b0;
		chk(bresp, er);
	endtask
	// Bus read; data and response are taken at the edge that sees rvalid.
	task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			n++;
		end
		while (rvalid !== 1'b1 && n < 50);
		if (n >= 50) hang();
		d = rdata;
		rready <= 1'b0;
		chk(rresp, er);
	endtask
	// One-cycle scan strobe, or power return strobe when pw is set.
	task automatic strobe(input logic pw);
		@(posedge aclk);
		power_lost <= pw;
		scan_tick <= !pw;
		@(posedge aclk);
		power_lost <= 1'b0;
		scan_tick <= 1'b0;
		@(posedge aclk);
	endtask
	// Main sequence.
	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		for (int a = 0; a < 6; a++)
		begin
			axr(8'(a * 4), rv, RESP_OKAY);
			chk(rv, 32'h0);
		end
		axr(8'h18, rv, RESP_SLVERR);
		chk(rv, 32'h0);
		axw(ADDR_COUNT, 32'h7, RESP_SLVERR);
		axw(ADDR_INIT, 32'h000f4241, RESP_OKAY);
		axr(ADDR_INIT, rv, RESP_OKAY);
		chk(rv, 32'(THR_MAX));
		// Only the low byte lane is written; the rest keeps the stored value.
		wstrb <= 4'h1;
		axw(ADDR_INIT, 32'h0, RESP_OKAY);
		wstrb <= 4'hf;
		axr(ADDR_INIT, rv, RESP_OKAY);
		chk(rv, 32'(THR_MAX) & 32'hffffff00);
		axw(ADDR_SET_THR, 32'(THR_MAX), RESP_OKAY);
		axr(ADDR_SET_THR, rv, RESP_OKAY);
		chk(rv, 32'(THR_MAX));
		$display("test registers done");
		// Hysteresis first, then window, each with a random walk.
		for (int m = 0; m < 2; m++)
		begin
			s = m ? 20'h3 : 20'h8;
			k = m ? 20'h8 : 20'h3;
			axw(ADDR_SET_THR, 32'(s), RESP_OKAY);
			axw(ADDR_CLR_THR, 32'(k), RESP_OKAY);
			axw(ADDR_INIT, 32'h5, RESP_OKAY);
			@(posedge aclk);
			count_reset <= 1'b1;
			i_udtc_pulse_src.fire(1'b0);
			strobe(1'b0);
			chk(count_value, 32'h5);
			chk(switch_out, 32'h0);
			// Status shows the reset level and the mode picked by threshold order.
			axr(ADDR_STATUS, rv, RESP_OKAY);
			chk(rv, m ? 32'h6 : 32'h4);
			@(posedge aclk);
			count_reset <= 1'b0;
			exp_cnt = 20'h5;
			exp_out = 1'b0;
			repeat (60)
			begin
				r = $random(seed);
				if (r[0])
				begin
					i_udtc_pulse_src.fire(r[1]);
					exp_cnt = step(exp_cnt, r[1]);
					chk(count_value, 32'(exp_cnt));
				end
				else
				begin
					exp_out = next_out(exp_cnt, s, k, exp_out);
					strobe(1'b0);
					chk(switch_out, 32'(exp_out));
				end
			end
			$display("test mode %0d done", m);
		end
		axw(ADDR_CTRL, 32'h1, RESP_OKAY);
		strobe(1'b1);
		chk(count_value, 32'(exp_cnt));
		axw(ADDR_CTRL, 32'h0, RESP_OKAY);
		strobe(1'b1);
		chk(count_value, 32'h0);
		chk(switch_out, 32'h0);
		i_udtc_pulse_src.fire(1'b1);
		chk(count_value, 32'h0);
		$display("test power done");
		@(posedge aclk);
		ext_set <= 32'hfffffffb;
		ext_clr <= 32'h001e8480;
		axw(ADDR_CTRL, 32'h6, RESP_OKAY);
		axr(ADDR_STATUS, rv, RESP_OKAY);
		chk(rv, 32'h2);
		strobe(1'b0);
		chk(switch_out, 32'h1);
		@(posedge aclk);
		ext_set <= 32'h0016e360;
		strobe(1'b0);
		chk(switch_out, 32'h0);
		$display("test external done");
		conclude();
	end
endmodule // udtc_counter_tb
`default_nettype wire
